// ### aocr_top.sv
// Output configuration register bank and test pattern generator
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Master bit gates all internal termination
// - Data buffer termination code, 000 none
// - Frame clock termination code, same mapping
// - Bit clock termination code, same mapping
// - Per channel noise suppression enable bits
// - 16-bit mode: bits drive main channels
// - 14-bit mode: bits drive B converters
// - Ramp replaces data, steps each sample
// - Dual pattern alternates A and B
// - Single pattern outputs A every sample
// - Pattern top bits from control register
// - Pattern low bits from registers 26/27
// - Master enable for word ordering control
// - Word-wise only with two-wire mode
module aocr_top
  import aocr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic sample_en_i,
  input wire logic [15:0] adc_data_i,
  input wire logic res14_mode_i,
  input wire logic two_wire_i,
  output logic [15:0] sample_o,
  output aocr_term_s term_o,
  output logic [NCH-1:0] chan_noise_suppress_enable_o,
  output logic [NCH-1:0] chan_noise_suppress_b_o,
  output logic [NCH-1:0] chan_whole_word_serial_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  aocr_state_s s_q;
  aocr_state_s s_d;
  logic [15:0] pat_a_full;
  logic [15:0] pat_b_full;

  // Top two bits from control, low fourteen from the pattern register
  function automatic logic [15:0] build_pat(input logic [1:0] hi, input logic [15:0] lo);
    build_pat = {hi, lo[PAT_LOW_LSB +: PAT_LOW_W]};
  endfunction

  assign pat_a_full = build_pat(s_q.pat_ctrl[PAT_A_HI_LSB +: 2], s_q.pat_a);
  assign pat_b_full = build_pat(s_q.pat_ctrl[PAT_B_HI_LSB +: 2], s_q.pat_b);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Fixed bits are masked, so stray ones from the host never stick
    if (wr_i) begin
      if (addr_i == ADDR_TERM) begin
        s_d.term = wdata_i & MASK_TERM;
      end else if (addr_i == ADDR_NOISE) begin
        s_d.noise = wdata_i & MASK_NOISE;
      end else if (addr_i == ADDR_PAT_CTRL) begin
        s_d.pat_ctrl = wdata_i & MASK_PAT_CTRL;
      end else if (addr_i == ADDR_PAT_A) begin
        s_d.pat_a = wdata_i & MASK_PAT_LOW;
      end else if (addr_i == ADDR_PAT_B) begin
        s_d.pat_b = wdata_i & MASK_PAT_LOW;
      end else if (addr_i == ADDR_WORD) begin
        s_d.word = wdata_i & MASK_WORD;
      end
    end
    s_d.rdata = RESET_VAL;
    if (rd_i) begin
      if (addr_i == ADDR_TERM) begin
        s_d.rdata = s_q.term;
      end else if (addr_i == ADDR_NOISE) begin
        s_d.rdata = s_q.noise;
      end else if (addr_i == ADDR_PAT_CTRL) begin
        s_d.rdata = s_q.pat_ctrl;
      end else if (addr_i == ADDR_PAT_A) begin
        s_d.rdata = s_q.pat_a;
      end else if (addr_i == ADDR_PAT_B) begin
        s_d.rdata = s_q.pat_b;
      end else if (addr_i == ADDR_WORD) begin
        s_d.rdata = s_q.word;
      end
    end
    // Mode picked by fixed priority
    if (s_q.pat_ctrl[RAMP_BIT]) begin
      s_d.mode = PAT_RAMP;
    end else if (s_q.pat_ctrl[DUAL_BIT]) begin
      s_d.mode = PAT_DUAL;
    end else if (s_q.pat_ctrl[SINGLE_BIT]) begin
      s_d.mode = PAT_SINGLE;
    end else begin
      s_d.mode = PAT_ADC;
    end
    if (sample_en_i) begin
      case (s_q.mode)
        PAT_RAMP: begin
          s_d.sample = s_q.ramp;
          s_d.ramp = s_q.ramp + RAMP_STEP;
        end
        PAT_DUAL: begin
          s_d.sample = s_q.sel_b ? pat_b_full : pat_a_full;
          s_d.sel_b = ~s_q.sel_b;
        end
        PAT_SINGLE: begin
          s_d.sample = pat_a_full;
        end
        default: begin
          s_d.sample = adc_data_i;
        end
      endcase
      // Restart patterns cleanly when they are not in use
      if (s_q.mode != PAT_RAMP) begin
        s_d.ramp = RESET_VAL;
      end
      if (s_q.mode != PAT_DUAL) begin
        s_d.sel_b = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Codes pass out while the enable bit is set, else 000; the pad cell maps code to resistance
  assign term_o.enable = s_q.term[TERM_EN_BIT];
  assign term_o.data_code = term_o.enable ?
    s_q.term[TERM_DATA_LSB +: TERM_CODE_W] : TERM_NONE;
  assign term_o.frame_code = term_o.enable ?
    s_q.term[TERM_FRAME_LSB +: TERM_CODE_W] : TERM_NONE;
  assign term_o.bit_code = term_o.enable ?
    s_q.term[TERM_BIT_LSB +: TERM_CODE_W] : TERM_NONE;
  assign chan_noise_suppress_enable_o = res14_mode_i ? '0 : s_q.noise[NCH-1:0];
  assign chan_noise_suppress_b_o = res14_mode_i ? s_q.noise[NCH-1:0] : '0;
  // Word-wise needs both the control enable and two-wire mode
  assign chan_whole_word_serial_o = (s_q.word[WORD_EN_BIT] && two_wire_i) ?
    s_q.word[NCH-1:0] : '0;
  assign rdata_o = s_q.rdata;
  assign sample_o = s_q.sample;
endmodule
`default_nettype wire

// ### aocr_pkg.sv
// Package for the output configuration register bank
package aocr_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TERM = 8'h12;
  localparam logic [7:0] ADDR_NOISE = 8'h14;
  localparam logic [7:0] ADDR_PAT_CTRL = 8'h25;
  localparam logic [7:0] ADDR_PAT_A = 8'h26;
  localparam logic [7:0] ADDR_PAT_B = 8'h27;
  localparam logic [7:0] ADDR_WORD = 8'h28;
  // ----------------------------------------------------------------
  // Writable bit masks, fixed zero bits excluded
  // ----------------------------------------------------------------
  localparam logic [15:0] MASK_TERM = 16'h4777;
  localparam logic [15:0] MASK_NOISE = 16'h000f;
  localparam logic [15:0] MASK_PAT_CTRL = 16'h007f;
  localparam logic [15:0] MASK_PAT_LOW = 16'hfffc;
  localparam logic [15:0] MASK_WORD = 16'h800f;
  localparam logic [15:0] RESET_VAL = 16'h0000;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TERM_EN_BIT = 14;
  localparam int RAMP_BIT = 6;
  localparam int DUAL_BIT = 5;
  localparam int SINGLE_BIT = 4;
  localparam int WORD_EN_BIT = 15;
  localparam int TERM_CODE_W = 3;
  localparam int TERM_DATA_LSB = 8;
  localparam int TERM_FRAME_LSB = 4;
  localparam int TERM_BIT_LSB = 0;
  localparam int PAT_A_HI_LSB = 0;
  localparam int PAT_B_HI_LSB = 2;
  localparam int PAT_LOW_LSB = 2;
  localparam int PAT_LOW_W = 14;
  localparam logic [2:0] TERM_NONE = 3'h0;
  localparam logic [15:0] RAMP_STEP = 16'h0001;
  localparam int NCH = 4;

  typedef enum logic [1:0] {
    PAT_ADC = 2'b00,
    PAT_RAMP = 2'b01,
    PAT_DUAL = 2'b10,
    PAT_SINGLE = 2'b11
  } aocr_pat_e;

  typedef struct packed {
    logic [15:0] term;
    logic [15:0] noise;
    logic [15:0] pat_ctrl;
    logic [15:0] pat_a;
    logic [15:0] pat_b;
    logic [15:0] word;
    logic [15:0] rdata;
    logic [15:0] ramp;
    logic [15:0] sample;
    logic sel_b;
    aocr_pat_e mode;
  } aocr_state_s;

  typedef struct packed {
    logic enable;
    logic [2:0] data_code;
    logic [2:0] frame_code;
    logic [2:0] bit_code;
  } aocr_term_s;
endpackage

// ### aocr_monitor.sv
// Port checker for the output config bank
`timescale 1ns/1ps
`default_nettype none
module aocr_monitor
  import aocr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic sample_en_i,
  input wire logic res14_mode_i,
  input wire logic two_wire_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] rdata_o,
  input wire logic [15:0] adc_data_i,
  input wire logic [15:0] sample_o,
  input wire aocr_term_s term_o,
  input wire logic [NCH-1:0] chan_noise_suppress_enable_o,
  input wire logic [NCH-1:0] chan_noise_suppress_b_o,
  input wire logic [NCH-1:0] chan_whole_word_serial_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_term_gate: assert property (!term_o.enable |-> term_o[8:0] == 9'h0)
    else $error("term code without enable");
  chk_term_load: assert property (wr_i && addr_i == ADDR_TERM |=>
    {1'b0, term_o.enable, 3'h0, term_o.data_code, 1'b0, term_o.frame_code, 1'b0,
    term_o.bit_code} == ($past(wdata_i) & ($past(wdata_i[14]) ? MASK_TERM : 16'h0)))
    else $error("term fields wrong");
  chk_noise_main: assert property (wr_i && addr_i == ADDR_NOISE ##1 !res14_mode_i |->
    16'(chan_noise_suppress_enable_o) == ($past(wdata_i) & MASK_NOISE))
    else $error("noise bits wrong");
  chk_noise_route: assert property (
    (res14_mode_i ? chan_noise_suppress_enable_o : chan_noise_suppress_b_o) == 4'h0)
    else $error("noise bits misrouted");
  chk_word_load: assert property (wr_i && addr_i == ADDR_WORD ##1 two_wire_i |->
    16'(chan_whole_word_serial_o) ==
    (($past(wdata_i) & 16'h8000) != 16'h0 ? $past(wdata_i) & 16'h000f : 16'h0))
    else $error("word bits wrong");
  chk_word_gate: assert property (!two_wire_i |-> chan_whole_word_serial_o == 4'h0)
    else $error("word-wise without two-wire");
  chk_rd_low: assert property (rd_i && addr_i == ADDR_PAT_A |=> rdata_o[1:0] == 2'h0)
    else $error("pattern low bits not zero");
  chk_smp_hold: assert property (!sample_en_i |=> $stable(sample_o))
    else $error("sample moved without enable");
endmodule
bind aocr_top aocr_monitor u_mon (.*);
`default_nettype wire

// ### aocr_host.sv
// Host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module aocr_host (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  output logic [7:0] addr_o = 8'h0,
  output logic [15:0] wdata_o = 16'h0,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0
);
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Testbench for the output config bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import aocr_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, sample_en_i = 1'b0, res14_mode_i = 1'b0;
  logic two_wire_i = 1'b0, wr_i, rd_i;
  logic [15:0] adc_data_i = 16'h5a3c, wdata_i, rdata_o, sample_o, rv;
  logic [7:0] addr_i;
  logic [NCH-1:0] chan_noise_suppress_enable_o, chan_noise_suppress_b_o, chan_whole_word_serial_o;
  aocr_term_s term_o;
  int errors = 0, num_checks = 0, cyc = 0;
  aocr_top DUT (.*);
  aocr_host HOST (.clk_i, .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
    .rd_o(rd_i));
  initial forever #5 clk_i = ~clk_i;
  // Far above the roughly 90 cycles the run needs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic smp(input logic [15:0] exp);
    @(posedge clk_i);
    sample_en_i <= 1'b1;
    @(posedge clk_i);
    sample_en_i <= 1'b0;
    #1 check(sample_o, exp);
  endtask
  task automatic t_term;
    for (int c = 0; c < 8; c++) begin
      HOST.wr_reg(ADDR_TERM, {2'h1, 3'h0, 3'(c), 1'b0, 3'(c + 1), 1'b0, 3'(7 - c)});
      #1 check(16'(term_o), {7'h1, 3'(c), 3'(c + 1), 3'(7 - c)});
    end
    HOST.wr_reg(ADDR_TERM, 16'h0777);
    #1 check(16'(term_o), 16'h0);
    HOST.rd_reg(ADDR_TERM, rv);
    check(rv, 16'h0777);
  endtask
  task automatic t_noise_word;
    HOST.wr_reg(ADDR_NOISE, 16'h000a);
    #1 check(16'({chan_noise_suppress_b_o, chan_noise_suppress_enable_o}), 16'ha);
    @(posedge clk_i);
    res14_mode_i <= 1'b1;
    two_wire_i <= 1'b1;
    #1 check(16'({chan_noise_suppress_b_o, chan_noise_suppress_enable_o}), 16'ha0);
    HOST.wr_reg(ADDR_WORD, 16'h8005);
    #1 check(16'(chan_whole_word_serial_o), 16'h5);
    HOST.wr_reg(ADDR_WORD, 16'h0005);
    #1 check(16'(chan_whole_word_serial_o), 16'h0);
    HOST.wr_reg(ADDR_WORD, 16'h800a);
    #1 check(16'(chan_whole_word_serial_o), 16'ha);
    @(posedge clk_i);
    two_wire_i <= 1'b0;
    #1 check(16'(chan_whole_word_serial_o), 16'h0);
  endtask
  task automatic t_pat;
    HOST.wr_reg(ADDR_PAT_A, 16'habcc);
    HOST.wr_reg(ADDR_PAT_B, 16'h1234);
    HOST.wr_reg(ADDR_PAT_CTRL, 16'h0026);
    smp(16'haaf3);
    smp(16'h448d);
    HOST.wr_reg(ADDR_PAT_CTRL, 16'h0016);
    smp(16'haaf3);
    HOST.wr_reg(ADDR_PAT_CTRL, 16'h0040);
    for (int i = 0; i < 3; i++) smp(16'(i));
    HOST.wr_reg(ADDR_PAT_CTRL, 16'h0070);
    smp(16'h0003);
    HOST.wr_reg(ADDR_PAT_CTRL, 16'h0036);
    smp(16'haaf3);
    HOST.wr_reg(ADDR_PAT_CTRL, 16'h0000);
    smp(16'h5a3c);
    HOST.rd_reg(ADDR_PAT_A, rv);
    check(rv, 16'habcc);
    HOST.rd_reg(8'h13, rv);
    check(rv, 16'h0);
  endtask
  // Mid-run reset must clear config and the sample register alike
  task automatic t_reset;
    HOST.wr_reg(ADDR_TERM, 16'h4123);
    #1 check(16'(term_o), 16'h0253);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1 check(16'(term_o), 16'h0);
    check(sample_o, 16'h0);
    HOST.rd_reg(ADDR_TERM, rv);
    check(rv, 16'h0);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_term();
    t_noise_word();
    t_pat();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
